/* logic/hdlc_ctrl_irq_regs.sv */
`timescale 1ns/1ps
`include "hdlc_ctrl_map.svh"

module hdlc_ctrl_irq_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] busAddr,
    input wire logic [7:0] busWrData,
    input wire logic busRead,
    input wire logic busWrite,
    output logic [7:0] busRdData,
    output logic irqRequest,
    input wire logic rxByteValid,
    output logic rxByteReady,
    input wire logic [7:0] rxByte,
    input wire logic rxByteEnd,
    input wire logic [7:0] rxFcsUpper,
    input wire logic rxFlagSeen,
    input wire logic rxBitTick,
    input wire logic rxPacketStart,
    input wire logic rxAbortSeen,
    input wire logic goAheadSeen,
    output logic storeValid,
    input wire logic storeReady,
    output logic [7:0] storeData,
    output logic storeEnd,
    input wire logic [7:0] rxLevel,
    input wire logic [7:0] rxStatusLevel,
    input wire logic [7:0] rxIrqLevel,
    input wire logic rxFifoRead,
    input wire logic rxNextIsLast,
    input wire logic [7:0] txLevel,
    input wire logic [7:0] txLowLevel,
    input wire logic txFifoWrite,
    input wire logic txReadAttempt,
    input wire logic txPacketDone,
    output logic rxEnable,
    output logic rxFlushActive,
    output logic txFlushActive,
    output logic txCycle,
    output logic txCrcInhibit,
    output logic sevenBitAddr,
    output logic [1:0] rxFifoState
);
    hdlc_ctrl_pkg::ctrl_state_t st;
    hdlc_ctrl_pkg::ctrl_state_t next_st;
    logic rdEdge;
    logic wrEdge;
    logic fifoInValid;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [8:0] fifoOutData;
    logic storeFull;
    logic storeWrite;
    logic overflowHit;
    logic abortCounts;
    logic [7:0] irqEvents;

    // Receive bytes pass a small buffer on their way to the byte store.
    byte_fifo #(
        .WIDTH(9),
        .DEPTH(4)
    ) u_rx_buffer (
        .mclk(mclk),
        .rst(rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData({rxByteEnd, rxByte}),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // While the receiver is disabled incoming bytes are taken and dropped.
    assign fifoInValid = rxByteValid && st.rxEnable;
    assign rxByteReady = fifoInReady || !st.rxEnable;

    // A byte meeting a full store is discarded and counts as an overflow.
    assign storeFull = (rxLevel >= `RX_FIFO_BYTES);
    assign storeValid = fifoOutValid && !storeFull;
    assign storeData = fifoOutData[7:0];
    assign storeEnd = fifoOutData[8];
    assign storeWrite = storeValid && storeReady;
    assign overflowHit = fifoOutValid && storeFull;
    assign fifoOutReady = storeReady || storeFull;

    // Bus strobes are pins: edges are taken after two synchroniser stages.
    assign rdEdge = st.rdSync[1] && !st.rdPrev;
    assign wrEdge = st.wrSync[1] && !st.wrPrev;

    // An abort only counts once enough packet bits have arrived.
    assign abortCounts = rxAbortSeen && (st.bitCount >= `ABORT_MIN_BITS);

    // Hardware events gathered per interrupt status bit.
    always_comb
    begin
        irqEvents = 8'h00;
        irqEvents[`IRQ_GO_AHEAD] = goAheadSeen;
        irqEvents[`IRQ_RX_END_PACKET] = storeWrite && storeEnd;
        irqEvents[`IRQ_TX_PACKET_DONE] = txPacketDone;
        irqEvents[`IRQ_RX_LAST_BYTE] = rxNextIsLast || (rxFifoRead && rxLevel == 8'h00);
        irqEvents[`IRQ_TX_FIFO_LOW] = (txLevel < txLowLevel) && (st.txLevelPrev >= txLowLevel);
        if (st.control[`CTL_IRQ_BIT2_SELECT])
        begin
            irqEvents[`IRQ_FRAME_ABORT] = txReadAttempt && (txLevel == 8'h00);
        end
        else
        begin
            irqEvents[`IRQ_FRAME_ABORT] = abortCounts;
        end
        irqEvents[`IRQ_RX_FIFO_HIGH] = (rxLevel > rxIrqLevel) && (st.rxLevelPrev <= rxIrqLevel);
        irqEvents[`IRQ_RX_OVERFLOW] = overflowHit;
    end

    // Next-state logic for registers, flags and receiver control.
    always_comb
    begin
        next_st = st;
        next_st.rdSync = {st.rdSync[0], busRead};
        next_st.wrSync = {st.wrSync[0], busWrite};
        next_st.rdPrev = st.rdSync[1];
        next_st.wrPrev = st.wrSync[1];
        // Address and write data are pins too and follow the strobes through two stages.
        next_st.addrSync = {st.addrSync[0], busAddr};
        next_st.wrDataSync = {st.wrDataSync[0], busWrData};
        next_st.rxLevelPrev = rxLevel;
        next_st.txLevelPrev = txLevel;
        // Packet bit counter saturates at the abort threshold.
        if (rxPacketStart)
        begin
            next_st.bitCount = 5'h00;
        end
        else if (rxBitTick && st.bitCount < `ABORT_MIN_BITS)
        begin
            next_st.bitCount = st.bitCount + 5'h01;
        end
        // Register reads; the interrupt status read clears all flags.
        if (rdEdge)
        begin
            case (st.addrSync[1])
                `ADDR_HDLC_STATUS: next_st.rdData = {6'h00, st.rxState};
                `ADDR_HDLC_CONTROL_TWO: next_st.rdData = st.control;
                `ADDR_HDLC_IRQ_MASK: next_st.rdData = st.mask;
                `ADDR_HDLC_IRQ_STATUS:
                begin
                    next_st.rdData = st.irq;
                    next_st.irq = 8'h00;
                end
                `ADDR_RX_CRC_UPPER: next_st.rdData = st.rxCrcUpper;
                default: next_st.rdData = 8'h00;
            endcase
        end
        // Register writes; reserved control bits are held at zero.
        if (wrEdge)
        begin
            case (st.addrSync[1])
                `ADDR_HDLC_CONTROL_TWO:
                begin
                    next_st.control = st.wrDataSync[1] & `CTL_WRITABLE_MASK;
                end
                `ADDR_HDLC_IRQ_MASK: next_st.mask = st.wrDataSync[1];
                default: next_st.control = st.control;
            endcase
        end
        // Transmit flush ends with the next transmit FIFO write.
        if (txFifoWrite)
        begin
            next_st.control[`CTL_TX_FIFO_FLUSH] = 1'b0;
        end
        // New events set flags after any clear, so a set is never lost.
        next_st.irq = next_st.irq | irqEvents;
        // Capture the received CRC upper byte with the end byte.
        if (storeWrite && storeEnd)
        begin
            next_st.rxCrcUpper = rxFcsUpper;
        end
        // Flush or overflow disables the receiver until the next flag seen with flush off and no overflow.
        if (overflowHit || next_st.control[`CTL_RX_FIFO_FLUSH])
        begin
            next_st.rxEnable = 1'b0;
        end
        else if (rxFlagSeen)
        begin
            next_st.rxEnable = 1'b1;
        end
        // Receive state encoding, forced empty while flushing.
        if (rxLevel == 8'h00 || st.control[`CTL_RX_FIFO_FLUSH])
        begin
            next_st.rxState = hdlc_ctrl_pkg::RX_EMPTY;
        end
        else if (rxLevel >= rxIrqLevel)
        begin
            next_st.rxState = hdlc_ctrl_pkg::RX_IRQ_LEVEL;
        end
        else if (rxLevel >= rxStatusLevel)
        begin
            next_st.rxState = hdlc_ctrl_pkg::RX_STATUS_LEVEL;
        end
        else
        begin
            next_st.rxState = hdlc_ctrl_pkg::RX_BELOW;
        end
    end

    // State register; the mask starts cleared so all sources are off.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.control <= `RST_CONTROL_TWO;
            st.mask <= `RST_IRQ_MASK;
            st.irq <= `RST_IRQ_STATUS;
            st.rxEnable <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register.
    assign busRdData = st.rdData;
    assign irqRequest = |(st.irq & st.mask);
    assign rxEnable = st.rxEnable;
    assign rxFlushActive = st.control[`CTL_RX_FIFO_FLUSH];
    assign txFlushActive = st.control[`CTL_TX_FIFO_FLUSH];
    assign txCycle = st.control[`CTL_CYCLE];
    assign txCrcInhibit = st.control[`CTL_TX_CRC_INHIBIT];
    assign sevenBitAddr = st.control[`CTL_SEVEN_BIT_ADDR];
    assign rxFifoState = st.rxState;

    // A read strobe reaches the register logic after two sync stages.
    sequence s_statusRead;
        rdEdge && st.addrSync[1] == `ADDR_HDLC_IRQ_STATUS;
    endsequence

    property p_read_clears;
        @(posedge mclk) disable iff (rst)
        s_statusRead ##0 (irqEvents == 8'h00) |=> (st.irq == 8'h00) && (busRdData == $past(st.irq));
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

    property p_set_wins;
        @(posedge mclk) disable iff (rst)
        s_statusRead ##0 (irqEvents != 8'h00) |=> (st.irq == $past(irqEvents));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost during clear");

    property p_irq_gate;
        @(posedge mclk) disable iff (rst)
        (st.irq != 8'h00 && st.mask == 8'h00) |-> !irqRequest;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("masked flag raised request");

    property p_overflow;
        @(posedge mclk) disable iff (rst)
        (overflowHit && !rxFlagSeen) |=> !rxEnable && st.irq[`IRQ_RX_OVERFLOW];
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not handled");

    property p_early_abort;
        @(posedge mclk) disable iff (rst)
        (rxAbortSeen && st.bitCount < `ABORT_MIN_BITS && !st.control[`CTL_IRQ_BIT2_SELECT]
            && st.irq[`IRQ_FRAME_ABORT] == 1'b0 && !rdEdge) |=> !st.irq[`IRQ_FRAME_ABORT];
    endproperty
    a_early_abort: assert property (p_early_abort) else $error("early abort flagged");

    property p_underrun;
        @(posedge mclk) disable iff (rst)
        (st.control[`CTL_IRQ_BIT2_SELECT] && txReadAttempt && txLevel == 8'h00)
            |=> st.irq[`IRQ_FRAME_ABORT];
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun not flagged");

    property p_tx_flush_clear;
        @(posedge mclk) disable iff (rst)
        (txFlushActive && txFifoWrite) |=> !txFlushActive;
    endproperty
    a_tx_flush_clear: assert property (p_tx_flush_clear) else $error("tx flush stuck");

    property p_rx_flush_empty;
        @(posedge mclk) disable iff (rst)
        rxFlushActive ##1 rxFlushActive |-> (rxFifoState == 2'h0) && !rxEnable;
    endproperty
    a_rx_flush_empty: assert property (p_rx_flush_empty) else $error("flush not empty");

    property p_crc_capture;
        @(posedge mclk) disable iff (rst)
        (storeWrite && storeEnd) |=> (st.rxCrcUpper == $past(rxFcsUpper))
            && st.irq[`IRQ_RX_END_PACKET];
    endproperty
    a_crc_capture: assert property (p_crc_capture) else $error("crc byte not captured");

    property p_go_ahead;
        @(posedge mclk) disable iff (rst)
        goAheadSeen |=> st.irq[`IRQ_GO_AHEAD];
    endproperty
    a_go_ahead: assert property (p_go_ahead) else $error("go-ahead not flagged");

    property p_rx_high;
        @(posedge mclk) disable iff (rst)
        (rxLevel > rxIrqLevel && $past(rxLevel) <= rxIrqLevel) |=> st.irq[`IRQ_RX_FIFO_HIGH];
    endproperty
    a_rx_high: assert property (p_rx_high) else $error("receive high not flagged");

    property p_tx_low;
        @(posedge mclk) disable iff (rst)
        (txLevel < txLowLevel && $past(txLevel) >= txLowLevel) |=> st.irq[`IRQ_TX_FIFO_LOW];
    endproperty
    a_tx_low: assert property (p_tx_low) else $error("transmit low not flagged");

    property p_rx_state_top;
        @(posedge mclk) disable iff (rst)
        (rxLevel != 8'h00 && !rxFlushActive && rxLevel >= rxIrqLevel) |=> (rxFifoState == 2'h3);
    endproperty
    a_rx_state_top: assert property (p_rx_state_top) else $error("receive state not top");

    property p_flags_hold;
        @(posedge mclk) disable iff (rst)
        !rdEdge |=> ((st.irq & $past(st.irq)) == $past(st.irq));
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flag cleared without read");

    property p_reserved_zero;
        @(posedge mclk) disable iff (rst)
        wrEdge |=> (st.control[3:2] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

endmodule : hdlc_ctrl_irq_regs

/* include/hdlc_ctrl_map.svh */
`ifndef HDLC_CTRL_MAP_SVH
`define HDLC_CTRL_MAP_SVH

// Register byte addresses on the parallel port.
`define ADDR_HDLC_STATUS 8'h14
`define ADDR_HDLC_CONTROL_TWO 8'h15
`define ADDR_HDLC_IRQ_MASK 8'h16
`define ADDR_HDLC_IRQ_STATUS 8'h17
`define ADDR_RX_CRC_UPPER 8'h1b

// Control register two bit positions.
`define CTL_IRQ_BIT2_SELECT 7
`define CTL_CYCLE 6
`define CTL_TX_CRC_INHIBIT 5
`define CTL_SEVEN_BIT_ADDR 4
`define CTL_RX_FIFO_FLUSH 1
`define CTL_TX_FIFO_FLUSH 0

// Interrupt status bit positions.
`define IRQ_GO_AHEAD 7
`define IRQ_RX_END_PACKET 6
`define IRQ_TX_PACKET_DONE 5
`define IRQ_RX_LAST_BYTE 4
`define IRQ_TX_FIFO_LOW 3
`define IRQ_FRAME_ABORT 2
`define IRQ_RX_FIFO_HIGH 1
`define IRQ_RX_OVERFLOW 0

// Reset values, sizes and counts.
`define RST_CONTROL_TWO 8'h00
`define RST_IRQ_MASK 8'h00
`define RST_IRQ_STATUS 8'h00
`define RX_FIFO_BYTES 8'h80
`define ABORT_MIN_BITS 5'h1a
`define CTL_WRITABLE_MASK 8'hf3

`endif

/* include/hdlc_ctrl_pkg.sv */
package hdlc_ctrl_pkg;

    // Receive FIFO fill state as reported in the status register.
    typedef enum logic [1:0] {
        RX_EMPTY = 2'h0,
        RX_BELOW = 2'h1,
        RX_STATUS_LEVEL = 2'h2,
        RX_IRQ_LEVEL = 2'h3
    } rx_fifo_state_t;

    // Complete register state of the control block.
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] mask;
        logic [7:0] irq;
        logic [7:0] rxCrcUpper;
        logic [7:0] rdData;
        logic [7:0] rxLevelPrev;
        logic [7:0] txLevelPrev;
        logic [4:0] bitCount;
        logic rxEnable;
        logic [1:0] rdSync;
        logic [1:0] wrSync;
        logic rdPrev;
        logic wrPrev;
        logic [1:0][7:0] addrSync;
        logic [1:0][7:0] wrDataSync;
        rx_fifo_state_t rxState;
    } ctrl_state_t;

endpackage : hdlc_ctrl_pkg

/* logic/byte_fifo.sv */
`timescale 1ns/1ps

// Small first-in first-out buffer with valid and ready on both sides.
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [CW-1:0] count;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic push;
    logic pop;

    // Handshakes come straight from the fill count.
    assign inReady = (st.count != CW'(DEPTH));
    assign outValid = (st.count != '0);
    assign outData = st.mem[st.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointer and count update; pointers wrap at the depth.
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wrPtr] = inData;
            next_st.wrPtr = (st.wrPtr == AW'(DEPTH - 1)) ? '0 : st.wrPtr + 1'b1;
        end
        if (pop)
        begin
            next_st.rdPtr = (st.rdPtr == AW'(DEPTH - 1)) ? '0 : st.rdPtr + 1'b1;
        end
        if (push && !pop)
        begin
            next_st.count = st.count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_st.count = st.count - 1'b1;
        end
    end

    // State register.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // The count goes up by one on each push that comes without a pop in the same cycle.
    property p_fifo_count;
        @(posedge mclk) disable iff (rst)
        (push && !pop) |=> (st.count == $past(st.count) + 1'b1);
    endproperty
    a_fifo_count: assert property (p_fifo_count) else $error("fifo count missed a push");

endmodule : byte_fifo

/* tb/rx_store_model.sv */
`timescale 1ns/1ps

// Receive store on the far side of the block: takes bytes and reports its fill level.
module rx_store_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic storeValid,
    output logic storeReady,
    input wire logic [7:0] storeData,
    input wire logic storeEnd,
    input wire logic rxFifoRead,
    input wire logic stall,
    input wire logic loadLevel,
    input wire logic [7:0] loadValue,
    output logic [7:0] rxLevel
);
    logic [8:0] stored[$];
    int level;

    // A full store refuses a byte, and so does a stalled one.
    assign storeReady = !stall && level < 128;
    assign rxLevel = 8'(level);

    // The level follows accepted bytes and processor reads, never dropping below empty.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            level <= 0;
        end
        else if (loadLevel)
        begin
            level <= int'(loadValue);
        end
        else
        begin
            if (storeValid && storeReady)
            begin
                stored.push_back({storeEnd, storeData});
            end
            level <= level + int'(storeValid && storeReady) - int'(rxFifoRead && level > 0);
        end
    end
endmodule : rx_store_model

/* tb/testbench.sv */
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module testbench;
    logic mclk = 1'b0, rst = 1'b1, busRead = 1'b0, busWrite = 1'b0;
    logic rxByteValid = 1'b0, rxByteEnd = 1'b0, stall = 1'b0, loadLevel = 1'b0;
    logic [7:0] busAddr = 8'h00, busWrData = 8'h00, rxByte = 8'h00, rxFcsUpper = 8'h00;
    logic [7:0] loadValue = 8'h00, rxStatusLevel = 8'h10, rxIrqLevel = 8'h40;
    logic [7:0] txLevel = 8'h05, txLowLevel = 8'h04;
    logic [9:0] evs = 10'h000;
    logic rxFlagSeen, txFifoWrite, rxPacketStart, rxBitTick, rxAbortSeen, txReadAttempt;
    logic rxFifoRead, rxNextIsLast, txPacketDone, goAheadSeen;
    logic [7:0] busRdData, storeData, rxLevel, d;
    logic irqRequest, rxByteReady, storeValid, storeReady, storeEnd, rxEnable;
    logic rxFlushActive, txFlushActive, txCycle, txCrcInhibit, sevenBitAddr;
    logic [1:0] rxFifoState;
    logic [8:0] expQ[$];
    int bad_count = 0, compares = 0, cycles = 0, expIrq = 0;
    int lv[5] = '{0, 5, 16, 64, 128};
    logic [1:0] st[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};

    // Event pulses are grouped so one task can raise any of them.
    assign {rxFlagSeen, txFifoWrite, rxPacketStart, rxBitTick, rxAbortSeen} = evs[9:5];
    assign {txReadAttempt, rxFifoRead, rxNextIsLast, txPacketDone, goAheadSeen} = evs[4:0];

    hdlc_ctrl_irq_regs u_hdlc_ctrl_irq_regs (
        .mclk(mclk),
        .rst(rst),
        .busAddr(busAddr),
        .busWrData(busWrData),
        .busRead(busRead),
        .busWrite(busWrite),
        .busRdData(busRdData),
        .irqRequest(irqRequest),
        .rxByteValid(rxByteValid),
        .rxByteReady(rxByteReady),
        .rxByte(rxByte),
        .rxByteEnd(rxByteEnd),
        .rxFcsUpper(rxFcsUpper),
        .rxFlagSeen(rxFlagSeen),
        .rxBitTick(rxBitTick),
        .rxPacketStart(rxPacketStart),
        .rxAbortSeen(rxAbortSeen),
        .goAheadSeen(goAheadSeen),
        .storeValid(storeValid),
        .storeReady(storeReady),
        .storeData(storeData),
        .storeEnd(storeEnd),
        .rxLevel(rxLevel),
        .rxStatusLevel(rxStatusLevel),
        .rxIrqLevel(rxIrqLevel),
        .rxFifoRead(rxFifoRead),
        .rxNextIsLast(rxNextIsLast),
        .txLevel(txLevel),
        .txLowLevel(txLowLevel),
        .txFifoWrite(txFifoWrite),
        .txReadAttempt(txReadAttempt),
        .txPacketDone(txPacketDone),
        .rxEnable(rxEnable),
        .rxFlushActive(rxFlushActive),
        .txFlushActive(txFlushActive),
        .txCycle(txCycle),
        .txCrcInhibit(txCrcInhibit),
        .sevenBitAddr(sevenBitAddr),
        .rxFifoState(rxFifoState)
    );
    rx_store_model u_rx_store_model (
        .mclk(mclk),
        .rst(rst),
        .storeValid(storeValid),
        .storeReady(storeReady),
        .storeData(storeData),
        .storeEnd(storeEnd),
        .rxFifoRead(rxFifoRead),
        .stall(stall),
        .loadLevel(loadLevel),
        .loadValue(loadValue),
        .rxLevel(rxLevel)
    );

    always #20 mclk = ~mclk;

    // Bus and event helpers; strobes stay high five cycles and low four.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] v);
        busAddr <= a;
        busWrData <= v;
        busRead <= !w;
        busWrite <= w;
        tick(5);
        d = busRdData;
        busRead <= 1'b0;
        busWrite <= 1'b0;
        tick(4);
    endtask : acc

    task automatic rdChk(input logic [7:0] a, input logic [7:0] ex, input string nm);
        acc(a, 1'b0, 8'h00);
        `CHK(nm, ex, d)
    endtask : rdChk

    task automatic irqChk();
        rdChk(8'h17, expIrq[7:0], "irq status");
        expIrq = 0;
    endtask : irqChk

    task automatic fire(input int i);
        evs[i] <= 1'b1;
        tick(1);
        evs[i] <= 1'b0;
        tick(2);
    endtask : fire

    // Loading past the interrupt level raises the receive high flag, so bit 1 joins the expected status.
    task automatic setLvl(input int v);
        if (v > 64 && u_rx_store_model.level <= 64)
            expIrq = expIrq | 2;
        loadValue <= 8'(v);
        loadLevel <= 1'b1;
        tick(1);
        loadLevel <= 1'b0;
        tick(2);
    endtask : setLvl

    task automatic sendByte(input logic [7:0] v, input logic e);
        int n;
        n = 0;
        rxByte <= v;
        rxByteEnd <= e;
        rxByteValid <= 1'b1;
        expQ.push_back({e, v});
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (rxByteReady !== 1'b1 && n < 50);
    endtask : sendByte

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    // A hang counts as a mismatch and closes the run.
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            bad_count++;
            results();
        end
    end

    // Main sequence.
    initial
    begin
        void'($urandom(61991));
        tick(5);
        rst <= 1'b0;
        tick(1);
        rdChk(8'h16, 8'h00, "mask");
        rdChk(8'h15, 8'h00, "control");
        irqChk();
        acc(8'h15, 1'b1, 8'hff);
        rdChk(8'h15, 8'hf3, "control");
        `CHK("ctl", 5'h1f, {txCycle, txCrcInhibit, sevenBitAddr, rxFlushActive, txFlushActive})
        `CHK("rxEnable", 1'b0, rxEnable)
        setLvl(5);
        `CHK("state", 2'h0, rxFifoState)
        fire(8);
        `CHK("txFlush", 1'b0, txFlushActive)
        rdChk(8'h15, 8'hf2, "control");
        acc(8'h15, 1'b1, 8'h00);
        fire(9);
        `CHK("rxEnable", 1'b1, rxEnable)
        for (int i = 0; i < 5; i++)
        begin
            setLvl(lv[i]);
            `CHK("state", st[i], rxFifoState)
            rdChk(8'h14, {6'h00, st[i]}, "status");
        end
        irqChk();
        setLvl(0);
        fire(0);
        fire(1);
        fire(2);
        expIrq = 8'hb0;
        irqChk();
        fire(3);
        expIrq = 8'h10;
        irqChk();
        txLevel <= 8'h02;
        tick(3);
        expIrq = 8'h08;
        irqChk();
        for (int n = 25; n <= 26; n++)
        begin
            fire(7);
            repeat (n) fire(6);
            fire(5);
            expIrq = (n == 26) ? 4 : 0;
            irqChk();
        end
        txLevel <= 8'h00;
        fire(4);
        irqChk();
        acc(8'h15, 1'b1, 8'h80);
        fire(4);
        expIrq = 4;
        irqChk();
        acc(8'h15, 1'b1, 8'h00);
        acc(8'h16, 1'b1, 8'h80);
        fire(1);
        `CHK("irqRequest", 1'b0, irqRequest)
        fire(0);
        `CHK("irqRequest", 1'b1, irqRequest)
        expIrq = 8'ha0;
        irqChk();
        `CHK("irqRequest", 1'b0, irqRequest)
        // An event landing on the clearing edge of a status read must survive.
        fork
            rdChk(8'h17, 8'h00, "irq status");
            begin
                tick(2);
                fire(0);
            end
        join
        `CHK("irqRequest", 1'b1, irqRequest)
        expIrq = 8'h80;
        irqChk();
        stall <= 1'b1;
        rxFcsUpper <= 8'($urandom);
        for (int i = 0; i < 4; i++)
            sendByte(8'($urandom), 1'b0);
        rxByteValid <= 1'b0;
        tick(2);
        `CHK("rxByteReady", 1'b0, rxByteReady)
        stall <= 1'b0;
        sendByte(8'($urandom), 1'b1);
        rxByteValid <= 1'b0;
        tick(12);
        `CHK("stored", expQ.size(), u_rx_store_model.stored.size())
        foreach (expQ[i])
            `CHK("byte", expQ[i], u_rx_store_model.stored[i])
        expIrq = 8'h40;
        irqChk();
        rdChk(8'h1b, rxFcsUpper, "crc upper");
        setLvl(128);
        sendByte(8'($urandom), 1'b0);
        rxByteValid <= 1'b0;
        tick(4);
        `CHK("rxEnable", 1'b0, rxEnable)
        expIrq = expIrq | 1;
        irqChk();
        fire(9);
        `CHK("rxEnable", 1'b1, rxEnable)
        results();
    end
endmodule : testbench
